/* File: pmbp_pkg.sv */
// Package for the program memory block protection logic.
// Assumes a core clock domain; all addresses are 22-bit byte addresses.
package pmbp_pkg;
    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 22;
    localparam logic [21:0] BOOT_END        = 22'h0001ff;
    localparam logic [21:0] BLK0_END        = 22'h001fff;
    localparam logic [21:0] BLK_STEP        = 22'h002000;
    localparam logic [21:0] USER_END        = 22'h007fff;
    localparam logic [21:0] ID_BASE         = 22'h200000;
    localparam logic [21:0] ID_END          = 22'h200007;
    localparam logic [21:0] CFG_BASE        = 22'h300000;
    localparam logic [21:0] CFG_END         = 22'h3000ff;
    localparam logic [21:0] DEVID_BASE      = 22'h3ffffe;
    localparam logic [21:0] DEVID_END       = 22'h3fffff;
    // ------------------------------------------------------------------
    // Protection configuration byte addresses
    // ------------------------------------------------------------------
    localparam logic [21:0] BLOCK_EXTERNAL_ACCESS_LOCK_ADDR       = 22'h300008;
    localparam logic [21:0] BOOT_EEPROM_EXTERNAL_ACCESS_LOCK_ADDR = 22'h300009;
    localparam logic [21:0] BLOCK_TABLE_WRITE_LOCK_ADDR           = 22'h30000a;
    localparam logic [21:0] BOOT_EEPROM_CONFIG_WRITE_LOCK_ADDR    = 22'h30000b;
    localparam logic [21:0] BLOCK_FOREIGN_READ_LOCK_ADDR          = 22'h30000c;
    localparam logic [21:0] BOOT_FOREIGN_READ_LOCK_ADDR           = 22'h30000d;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int NREG            = 5;   // Boot plus four blocks
    localparam int BOOT_IDX        = 4;   // Index of boot region in masks
    localparam int HI_EEPROM_BIT   = 7;
    localparam int HI_BOOT_BIT     = 6;
    localparam int HI_CFG_BIT      = 5;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Region code from decoder
    typedef enum logic [2:0] {
        PMBP_REG_BLK0 = 3'h0,
        PMBP_REG_BLK1 = 3'h1,
        PMBP_REG_BLK2 = 3'h2,
        PMBP_REG_BLK3 = 3'h3,
        PMBP_REG_BOOT = 3'h4,
        PMBP_REG_NONE = 3'h7
    } pmbp_region_type;

    // Core table request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [21:0] ptr;
        logic [21:0] pc;
        logic [7:0]  wdata;
    } pmbp_core_req_type;

    // External programmer request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        eeprom;   // Target is data EEPROM
        logic        chip_erase;
        logic        blk_erase;
        logic [21:0] addr;
        logic [7:0]  wdata;
    } pmbp_ext_req_type;

    // Protection bits: three masks with one bit per region, plus single EEPROM and config bits
    typedef struct packed {
        logic [NREG-1:0] ext_access;
        logic [NREG-1:0] tbl_write;
        logic [NREG-1:0] foreign_read;
        logic            eeprom_access;
        logic            eeprom_write;
        logic            cfg_write;
    } pmbp_prot_type;
endpackage : pmbp_pkg

/* File: pmbp_region_decode.sv */
// Region decoder: maps a byte address onto a protection region.
// Purely combinational; used for pointer, program counter and programmer address.
`timescale 1ns/100ps
`default_nettype none
module pmbp_region_decode
    import pmbp_pkg::*;
(
    input  wire logic [21:0]     addr_i,
    output var  pmbp_region_type region_o
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Boundaries are binary so comparisons stay cheap
    always_comb begin
        if (addr_i <= BOOT_END) begin
            region_o = PMBP_REG_BOOT;
        end else if (addr_i <= BLK0_END) begin
            region_o = PMBP_REG_BLK0;
        end else if (addr_i <= BLK0_END + BLK_STEP) begin
            region_o = PMBP_REG_BLK1;
        end else if (addr_i <= BLK0_END + 22'(2 * BLK_STEP)) begin
            region_o = PMBP_REG_BLK2;
        end else if (addr_i <= USER_END) begin
            region_o = PMBP_REG_BLK3;
        end else begin
            region_o = PMBP_REG_NONE;
        end
    end
endmodule : pmbp_region_decode
`default_nettype wire

/* File: pmbp_top.sv */
// Program memory block protection: gates core table operations and
// external programmer accesses with one-time-clearable lock bits.
// Assumes a flash/EEPROM array beside it that answers in the same cycle.
// Core requests are one-cycle pulses from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pmbp_top
    import pmbp_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    input  wire pmbp_core_req_type CORE_REQ_I,
    input  wire logic [7:0]        MEM_RDATA_I,
    input  wire pmbp_ext_req_type  EXT_REQ_I,
    output var  logic [7:0]        TABLE_LATCH_O,
    output var  logic              MEM_WR_O,
    output var  logic [21:0]       MEM_ADDR_O,
    output var  logic [7:0]        MEM_WDATA_O,
    output var  logic              EXT_RD_VALID_O,
    output var  logic [7:0]        EXT_RDATA_O,
    output var  logic              EXT_REFUSED_O,
    output var  logic              EXT_EEPROM_WR_O,
    output var  pmbp_prot_type     PROT_O
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Everything the block remembers, registered as one word
    typedef struct packed {
        pmbp_prot_type prot;
        logic [7:0]    table_latch;
        logic          mem_wr;
        logic [21:0]   mem_addr;
        logic [7:0]    mem_wdata;
        logic          ext_rd_valid;
        logic [7:0]    ext_rdata;
        logic          ext_refused;
        logic          ext_eeprom_wr;
    } pmbp_state_type;

    // Register and its next value
    pmbp_state_type  state_q;
    pmbp_state_type  state_d;
    // Decoder results for the request in this cycle
    pmbp_region_type ptr_region;
    pmbp_region_type pc_region;
    pmbp_region_type ext_region;

    // ------------------------------------------------------------------
    // Region decoders
    // ------------------------------------------------------------------
    // Pointer and PC decoded side by side so the read check is single cycle
    pmbp_region_decode u_ptr_dec (
        .addr_i   (CORE_REQ_I.ptr),
        .region_o (ptr_region)
    );
    pmbp_region_decode u_pc_dec (
        .addr_i   (CORE_REQ_I.pc),
        .region_o (pc_region)
    );
    // Programmer has its own decoder so both paths run at once
    pmbp_region_decode u_ext_dec (
        .addr_i   (EXT_REQ_I.addr),
        .region_o (ext_region)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Index into the per-region masks; NONE means no lock applies
    // The guard keeps code 7 from indexing past the five-bit masks
    function automatic logic lock_open(input logic [NREG-1:0] mask,
                                       input pmbp_region_type r);
        if (r == PMBP_REG_NONE) begin
            return 1'b1;
        end
        return mask[r];
    endfunction : lock_open

    // Read image of a lock byte, unused positions zero
    // Lock bytes live here, not in the array, so reads never reach it
    function automatic logic [7:0] lock_byte(input pmbp_prot_type p,
                                             input logic [21:0] a);
        logic [7:0] v;
        v = ZERO_BYTE;
        unique case (a)
            BLOCK_EXTERNAL_ACCESS_LOCK_ADDR:
                v[NREG-2:0] = p.ext_access[NREG-2:0];
            BOOT_EEPROM_EXTERNAL_ACCESS_LOCK_ADDR: begin
                v[HI_EEPROM_BIT] = p.eeprom_access;
                v[HI_BOOT_BIT]   = p.ext_access[BOOT_IDX];
            end
            BLOCK_TABLE_WRITE_LOCK_ADDR:
                v[NREG-2:0] = p.tbl_write[NREG-2:0];
            BOOT_EEPROM_CONFIG_WRITE_LOCK_ADDR: begin
                v[HI_EEPROM_BIT] = p.eeprom_write;
                v[HI_BOOT_BIT]   = p.tbl_write[BOOT_IDX];
                v[HI_CFG_BIT]    = p.cfg_write;
            end
            BLOCK_FOREIGN_READ_LOCK_ADDR:
                v[NREG-2:0] = p.foreign_read[NREG-2:0];
            BOOT_FOREIGN_READ_LOCK_ADDR:
                v[HI_BOOT_BIT]   = p.foreign_read[BOOT_IDX];
            default: v = ZERO_BYTE;
        endcase
        return v;
    endfunction : lock_byte

    // Apply a byte write; AND keeps bits one-way toward zero
    // Only programmer writes, marked by from_ext, reach the config lock
    function automatic pmbp_prot_type lock_write(input pmbp_prot_type p,
                                                 input logic [21:0] a,
                                                 input logic [7:0] d,
                                                 input logic from_ext);
        pmbp_prot_type n;
        n = p;
        unique case (a)
            BLOCK_EXTERNAL_ACCESS_LOCK_ADDR:
                n.ext_access[NREG-2:0] = p.ext_access[NREG-2:0] & d[NREG-2:0];
            BOOT_EEPROM_EXTERNAL_ACCESS_LOCK_ADDR: begin
                n.eeprom_access        = p.eeprom_access & d[HI_EEPROM_BIT];
                n.ext_access[BOOT_IDX] = p.ext_access[BOOT_IDX] & d[HI_BOOT_BIT];
            end
            BLOCK_TABLE_WRITE_LOCK_ADDR:
                n.tbl_write[NREG-2:0] = p.tbl_write[NREG-2:0] & d[NREG-2:0];
            BOOT_EEPROM_CONFIG_WRITE_LOCK_ADDR: begin
                n.eeprom_write        = p.eeprom_write & d[HI_EEPROM_BIT];
                n.tbl_write[BOOT_IDX] = p.tbl_write[BOOT_IDX] & d[HI_BOOT_BIT];
                if (from_ext) begin
                    n.cfg_write = p.cfg_write & d[HI_CFG_BIT];
                end
            end
            BLOCK_FOREIGN_READ_LOCK_ADDR:
                n.foreign_read[NREG-2:0] = p.foreign_read[NREG-2:0] & d[NREG-2:0];
            BOOT_FOREIGN_READ_LOCK_ADDR:
                n.foreign_read[BOOT_IDX] = p.foreign_read[BOOT_IDX] & d[HI_BOOT_BIT];
            default: n = p;
        endcase
        return n;
    endfunction : lock_write

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Address class of the core pointer
    logic in_user;
    logic in_id;
    logic in_cfg;
    logic in_devid;
    logic in_lock;
    // Permission results for this cycle's requests
    logic wr_ok;
    logic rd_ok;
    logic ext_ok;
    logic ext_in_lock;

    // One pass serves core and programmer; programmer writes land after core writes, erase last
    always_comb begin
        // Pulses fall back low unless a request raises them this cycle
        state_d = state_q;
        state_d.mem_wr        = 1'b0;
        state_d.ext_rd_valid  = 1'b0;
        state_d.ext_refused   = 1'b0;
        state_d.ext_eeprom_wr = 1'b0;
        // Classify the pointer once; both core table branches below reuse it
        in_user  = CORE_REQ_I.ptr <= USER_END;
        in_id    = (CORE_REQ_I.ptr >= ID_BASE) && (CORE_REQ_I.ptr <= ID_END);
        in_cfg   = (CORE_REQ_I.ptr >= CFG_BASE) && (CORE_REQ_I.ptr <= CFG_END);
        in_devid = (CORE_REQ_I.ptr >= DEVID_BASE) && (CORE_REQ_I.ptr <= DEVID_END);
        // Lock bytes sit inside the configuration window
        in_lock  = (CORE_REQ_I.ptr >= BLOCK_EXTERNAL_ACCESS_LOCK_ADDR)
                && (CORE_REQ_I.ptr <= BOOT_FOREIGN_READ_LOCK_ADDR);
        ext_in_lock = (EXT_REQ_I.addr >= BLOCK_EXTERNAL_ACCESS_LOCK_ADDR)
                   && (EXT_REQ_I.addr <= BOOT_FOREIGN_READ_LOCK_ADDR);
        // External-access bits are not consulted on the core path
        wr_ok = (in_user && lock_open(state_q.prot.tbl_write, ptr_region))
             || in_id || (in_cfg && state_q.prot.cfg_write);
        // Same-region reads always pass; foreign reads need the bit set
        // A pointer outside user memory has no region lock at all
        rd_ok = (ptr_region == pc_region)
             || lock_open(state_q.prot.foreign_read, ptr_region);

        // ------------------------------------------------------------------
        // Core table path
        // ------------------------------------------------------------------
        // Core table read: latch data, or zeros when blocked
        // Latch keeps its value between reads, as the core expects
        if (CORE_REQ_I.rd) begin
            if (in_lock) begin
                state_d.table_latch = lock_byte(state_q.prot, CORE_REQ_I.ptr);
            end else if (in_user && !rd_ok) begin
                state_d.table_latch = ZERO_BYTE;
            end else if (in_user || in_id || in_cfg || in_devid) begin
                state_d.table_latch = MEM_RDATA_I;
            end else begin
                state_d.table_latch = ZERO_BYTE;
            end
        end
        // Core table write: suppressed writes leave everything untouched
        // A dropped write raises nothing, so the core cannot see it
        if (CORE_REQ_I.wr && wr_ok) begin
            if (in_lock) begin
                state_d.prot = lock_write(state_d.prot, CORE_REQ_I.ptr,
                                          CORE_REQ_I.wdata, 1'b0);
            end else begin
                state_d.mem_wr    = 1'b1;
                state_d.mem_addr  = CORE_REQ_I.ptr;
                state_d.mem_wdata = CORE_REQ_I.wdata;
            end
        end

        // ------------------------------------------------------------------
        // External programmer path
        // ------------------------------------------------------------------
        // Requests are judged against the locks as they stood last cycle
        if (EXT_REQ_I.eeprom) begin
            // Core EEPROM access is elsewhere and never gated here
            ext_ok = state_q.prot.eeprom_access
                  && (!EXT_REQ_I.wr || state_q.prot.eeprom_write);
        end else begin
            ext_ok = lock_open(state_q.prot.ext_access, ext_region);
        end
        // Refused reads still answer, with zero data, so nothing waits
        if (EXT_REQ_I.rd) begin
            state_d.ext_rd_valid = 1'b1;
            state_d.ext_refused  = !ext_ok;
            state_d.ext_rdata    = ZERO_BYTE;
            if (ext_ok && !EXT_REQ_I.eeprom) begin
                state_d.ext_rdata = ext_in_lock ? lock_byte(state_q.prot, EXT_REQ_I.addr)
                                                : MEM_RDATA_I;
            end
        end
        // Applied after the core's write, so both clears land together
        if (EXT_REQ_I.wr) begin
            state_d.ext_refused = !ext_ok;
            if (ext_ok) begin
                state_d.prot = lock_write(state_d.prot, EXT_REQ_I.addr,
                                          EXT_REQ_I.wdata, 1'b1);
                state_d.ext_eeprom_wr = EXT_REQ_I.eeprom;
            end
        end

        // ------------------------------------------------------------------
        // Erase
        // ------------------------------------------------------------------
        // Erase only arrives on the programmer port; erase wins over clears
        // Block erase reopens every lock; per-block erase is not modelled
        if (EXT_REQ_I.chip_erase || EXT_REQ_I.blk_erase) begin
            state_d.prot = '1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset leaves locks open, standing in for an erased part
    // Limitation: locks are volatile here, unlike nonvolatile cells
    // Synchronous reset, so no state survives it
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_q      <= '0;
            state_q.prot <= '1;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a register bit, nothing combinational leaves
    assign TABLE_LATCH_O   = state_q.table_latch;
    assign MEM_WR_O        = state_q.mem_wr;
    assign MEM_ADDR_O      = state_q.mem_addr;
    assign MEM_WDATA_O     = state_q.mem_wdata;
    assign EXT_RD_VALID_O  = state_q.ext_rd_valid;
    assign EXT_RDATA_O     = state_q.ext_rdata;
    assign EXT_REFUSED_O   = state_q.ext_refused;
    assign EXT_EEPROM_WR_O = state_q.ext_eeprom_wr;
    assign PROT_O          = state_q.prot;
endmodule : pmbp_top
`default_nettype wire

/* File: pmbp_assertions.sv */
// Concurrent checks on the ports of the block protection top.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pmbp_assertions
    import pmbp_pkg::*;
(
    input wire logic              CLK_I,
    input wire logic              RST_N_I,
    input wire pmbp_core_req_type CORE_REQ_I,
    input wire logic [7:0]        MEM_RDATA_I,
    input wire pmbp_ext_req_type  EXT_REQ_I,
    input wire logic [7:0]        TABLE_LATCH_O,
    input wire logic              MEM_WR_O,
    input wire logic [21:0]       MEM_ADDR_O,
    input wire logic [7:0]        MEM_WDATA_O,
    input wire logic              EXT_RD_VALID_O,
    input wire logic [7:0]        EXT_RDATA_O,
    input wire logic              EXT_REFUSED_O,
    input wire logic              EXT_EEPROM_WR_O,
    input wire pmbp_prot_type     PROT_O
);
    // Region index: 0..3 blocks, 4 boot, 7 outside user memory
    function automatic logic [2:0] rgn(input logic [21:0] a);
        if (a <= BOOT_END) return 3'h4;
        if (a > USER_END) return 3'h7;
        return {1'b0, a[14:13]};
    endfunction : rgn

    logic [2:0] rp, rc, re;
    logic       wlk, rlk, elk, ers;
    // Lock lookups guarded so region 7 never indexes past the masks
    assign rp  = rgn(CORE_REQ_I.ptr);
    assign rc  = rgn(CORE_REQ_I.pc);
    assign re  = rgn(EXT_REQ_I.addr);
    assign wlk = (rp < 3'h5) && !PROT_O.tbl_write[rp];
    assign rlk = (rp < 3'h5) && !PROT_O.foreign_read[rp] && (rc != rp);
    assign elk = (re < 3'h5) && !PROT_O.ext_access[re];
    assign ers = EXT_REQ_I.chip_erase || EXT_REQ_I.blk_erase;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_wr_locked;
        CORE_REQ_I.wr && wlk;
    endsequence
    sequence s_wr_open;
        CORE_REQ_I.wr && (rp < 3'h5) && !wlk;
    endsequence

    a_write_blocked: assert property (s_wr_locked |=> !MEM_WR_O)
        else $error("locked table write reached the array");
    a_write_passed: assert property (s_wr_open |=> MEM_WR_O && MEM_ADDR_O == $past(CORE_REQ_I.ptr)
        && MEM_WDATA_O == $past(CORE_REQ_I.wdata))
        else $error("open table write not forwarded");
    a_foreign_zero: assert property (CORE_REQ_I.rd && rlk |=> TABLE_LATCH_O == 8'h00)
        else $error("foreign read of locked region leaked data");
    a_read_data: assert property (CORE_REQ_I.rd && (rp < 3'h5) && !rlk
        |=> TABLE_LATCH_O == $past(MEM_RDATA_I))
        else $error("permitted table read lost its data");
    a_locks_one_way: assert property (!ers |=> (PROT_O & ~$past(PROT_O)) == '0)
        else $error("lock bit went from zero to one");
    a_erase_all_ones: assert property (ers |=> PROT_O == '1)
        else $error("erase did not set every lock bit");
    a_ext_refused: assert property (EXT_REQ_I.rd && !EXT_REQ_I.eeprom && elk
        |=> EXT_REFUSED_O && EXT_RDATA_O == 8'h00)
        else $error("locked region read by programmer");
    a_eeprom_guard: assert property (EXT_REQ_I.wr && EXT_REQ_I.eeprom
        && !(PROT_O.eeprom_access && PROT_O.eeprom_write) |=> EXT_REFUSED_O && !EXT_EEPROM_WR_O)
        else $error("locked eeprom written by programmer");
    a_cfg_bit_core: assert property (CORE_REQ_I.wr && CORE_REQ_I.ptr == BOOT_EEPROM_CONFIG_WRITE_LOCK_ADDR
        && !EXT_REQ_I.wr && !ers |=> $stable(PROT_O.cfg_write))
        else $error("core changed the config write lock");
endmodule : pmbp_assertions

bind pmbp_top pmbp_assertions u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CORE_REQ_I(CORE_REQ_I),
    .MEM_RDATA_I(MEM_RDATA_I), .EXT_REQ_I(EXT_REQ_I), .TABLE_LATCH_O(TABLE_LATCH_O), .MEM_WR_O(MEM_WR_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .EXT_RD_VALID_O(EXT_RD_VALID_O),
    .EXT_RDATA_O(EXT_RDATA_O), .EXT_REFUSED_O(EXT_REFUSED_O), .EXT_EEPROM_WR_O(EXT_EEPROM_WR_O),
    .PROT_O(PROT_O));
`default_nettype wire

/* File: pmbp_array_model.sv */
// Program array model that answers reads in the same cycle.
// Assumes the block reads at the ext address while an ext read is pending.
`timescale 1ns/100ps
`default_nettype none
module pmbp_array_model (
    input  wire logic [21:0] core_ptr_i,
    input  wire logic [21:0] ext_addr_i,
    input  wire logic        ext_rd_i,
    output var  logic [7:0]  rdata_o
);
    logic [21:0] sel;
    // Address pattern, so a read from the wrong place cannot match
    always_comb begin
        sel     = ext_rd_i ? ext_addr_i : core_ptr_i;
        rdata_o = sel[7:0] ^ sel[15:8] ^ 8'h3c;
    end
endmodule : pmbp_array_model
`default_nettype wire

/* File: program_memory_block_protect_bench.sv */
// Self-checking bench: core and programmer requests with expected results.
// Assumes the array model beside the block; the core has no erase path.
`timescale 1ns/100ps
`default_nettype none
module program_memory_block_protect_bench;
    import pmbp_pkg::*;
    logic              clk, rst_n, mwr, rdv, refd, eewr;
    pmbp_core_req_type creq;
    pmbp_ext_req_type  ereq;
    pmbp_prot_type     prot, ep;
    logic [7:0]        rdata, latch, mwd, erd;
    logic [21:0]       madr;
    int                err_total, n_checks, cyc;
    logic [7:0]        cfg_exp [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
    logic [21:0]       wr_adr [4] = '{22'h001fff, 22'h002000, 22'h003fff, 22'h004000};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    pmbp_top uut (.CLK_I(clk), .RST_N_I(rst_n), .CORE_REQ_I(creq), .MEM_RDATA_I(rdata), .EXT_REQ_I(ereq),
        .TABLE_LATCH_O(latch), .MEM_WR_O(mwr), .MEM_ADDR_O(madr), .MEM_WDATA_O(mwd), .EXT_RD_VALID_O(rdv),
        .EXT_RDATA_O(erd), .EXT_REFUSED_O(refd), .EXT_EEPROM_WR_O(eewr), .PROT_O(prot));
    pmbp_array_model u_arr (.core_ptr_i(creq.ptr), .ext_addr_i(ereq.addr), .ext_rd_i(ereq.rd), .rdata_o(rdata));

    function automatic logic [7:0] bpat(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : bpat
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One table operation, one cycle wide; the core can never erase
    task automatic core(input logic wr, input logic [21:0] ptr, input logic [21:0] pc, input logic [7:0] d);
        @(posedge clk);
        creq <= '{rd: !wr, wr: wr, ptr: ptr, pc: pc, wdata: d};
        @(posedge clk);
        creq.rd <= 1'b0;
        creq.wr <= 1'b0;
        #1;
    endtask : core
    task automatic ext(input logic [4:0] op, input logic [21:0] a, input logic [7:0] d);
        @(posedge clk);
        ereq <= '{op[4], op[3], op[2], op[1], op[0], a, d};
        @(posedge clk);
        ereq <= '0;
        #1;
    endtask : ext
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // Cycle ceiling well above the roughly 85 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; creq = '0; ereq = '0; ep = '1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("prot_rst", 32'(prot), 32'(ep));
        for (int i = 0; i < 6; i++) begin
            core(1'b0, BLOCK_EXTERNAL_ACCESS_LOCK_ADDR + 22'(i), 22'h000400, 8'h00);
            chk("lock_byte", 32'(latch), 32'(cfg_exp[i]));
        end
        core(1'b0, ID_BASE, 22'h000400, 8'h00);
        chk("id_rd", 32'(latch), 32'(bpat(ID_BASE)));
        core(1'b0, 22'h000fff, 22'h002ffe, 8'h00);
        chk("rd_open", 32'(latch), 32'(bpat(22'h000fff)));
        ext(5'h08, BLOCK_FOREIGN_READ_LOCK_ADDR, 8'hfe);
        ep.foreign_read[0] = 1'b0;
        ext(5'h08, BLOCK_FOREIGN_READ_LOCK_ADDR, 8'hff);
        chk("prot_clr", 32'(prot), 32'(ep));
        core(1'b0, 22'h000fff, 22'h002ffe, 8'h00);
        chk("rd_foreign", 32'(latch), 32'h0);
        core(1'b0, 22'h000fff, 22'h000200, 8'h00);
        chk("rd_own", 32'(latch), 32'(bpat(22'h000fff)));
        ext(5'h08, BOOT_FOREIGN_READ_LOCK_ADDR, 8'hbf);
        ep.foreign_read[4] = 1'b0;
        core(1'b0, 22'h0001ff, 22'h000200, 8'h00);
        chk("boot_foreign", 32'(latch), 32'h0);
        core(1'b0, 22'h0001ff, 22'h000000, 8'h00);
        chk("boot_own", 32'(latch), 32'(bpat(22'h0001ff)));
        ext(5'h08, BLOCK_TABLE_WRITE_LOCK_ADDR, 8'hfd);
        ep.tbl_write[1] = 1'b0;
        for (int i = 0; i < 4; i++) begin
            core(1'b1, wr_adr[i], 22'h000400, 8'ha5);
            chk("mem_wr", 32'(mwr), 32'(i == 0 || i == 3));
        end
        chk("mem_adr", 32'(madr), 32'(22'h004000));
        chk("mem_wd", 32'(mwd), 32'h000000a5);
        core(1'b1, BLOCK_TABLE_WRITE_LOCK_ADDR, 22'h000400, 8'hfb);
        ep.tbl_write[2] = 1'b0;
        core(1'b1, BOOT_EEPROM_CONFIG_WRITE_LOCK_ADDR, 22'h000400, 8'hdf);
        chk("prot_core", 32'(prot), 32'(ep));
        ext(5'h08, BLOCK_EXTERNAL_ACCESS_LOCK_ADDR, 8'hf7);
        ep.ext_access[3] = 1'b0;
        ext(5'h10, 22'h006000, 8'h00);
        chk("ext_lock", 32'({refd, rdv, erd}), 32'h300);
        ext(5'h10, 22'h005fff, 8'h00);
        chk("ext_open", 32'({refd, rdv, erd}), {22'h0, 2'b01, bpat(22'h005fff)});
        core(1'b0, 22'h006000, 22'h006002, 8'h00);
        chk("core_cp", 32'(latch), 32'(bpat(22'h006000)));
        ext(5'h0c, 22'h000010, 8'h11);
        chk("ee_wr", 32'({refd, eewr}), 32'h1);
        ext(5'h08, BOOT_EEPROM_CONFIG_WRITE_LOCK_ADDR, 8'h5f);
        ep.eeprom_write = 1'b0;
        ep.cfg_write = 1'b0;
        ext(5'h0c, 22'h000010, 8'h11);
        chk("ee_wlock", 32'({refd, eewr}), 32'h2);
        ext(5'h14, 22'h000010, 8'h00);
        chk("ee_rd", 32'(refd), 32'h0);
        ext(5'h08, BOOT_EEPROM_EXTERNAL_ACCESS_LOCK_ADDR, 8'h7f);
        ep.eeprom_access = 1'b0;
        ext(5'h14, 22'h000010, 8'h00);
        chk("ee_alock", 32'(refd), 32'h1);
        core(1'b1, BLOCK_TABLE_WRITE_LOCK_ADDR, 22'h000400, 8'h00);
        chk("prot_cfgw", 32'(prot), 32'(ep));
        ext(5'h02, 22'h000000, 8'h00);
        ep = '1;
        chk("chip_erase", 32'(prot), 32'(ep));
        ext(5'h08, BLOCK_EXTERNAL_ACCESS_LOCK_ADDR, 8'h00);
        ext(5'h01, 22'h000000, 8'h00);
        chk("blk_erase", 32'(prot), 32'(ep));
        tally_and_finish();
    end
endmodule : program_memory_block_protect_bench
`default_nettype wire
